// File: hdl/cfgbr_pkg.sv
// Package of constants and types for the configurable block RAM
package cfgbr_pkg;
  // Array geometry
  localparam int MEM_BYTES = 512;
  localparam int BYTE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 36;
  localparam logic [8:0] HALF_BIT = 9'h100;
  // Operating modes
  localparam logic [2:0] MODE_TDP = 3'h0;
  localparam logic [2:0] MODE_SDP = 3'h1;
  localparam logic [2:0] MODE_SP = 3'h2;
  localparam logic [2:0] MODE_SP2 = 3'h3;
  localparam logic [2:0] MODE_ROM = 3'h4;
  localparam logic [2:0] MODE_SHIFT = 3'h5;
  // Port width codes, data width is 1 << code (parity adds 1 per byte)
  localparam logic [2:0] WC_1 = 3'h0;
  localparam logic [2:0] WC_2 = 3'h1;
  localparam logic [2:0] WC_4 = 3'h2;
  localparam logic [2:0] WC_8 = 3'h3;
  localparam logic [2:0] WC_16 = 3'h4;
  localparam logic [2:0] WC_32 = 3'h5;
  // APB register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] SHIFT_OFF = 12'h004;
  localparam logic [11:0] STAT_OFF = 12'h008;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WA_LSB = 4;
  localparam int CTRL_WB_LSB = 8;
  localparam int CTRL_PAR_A = 12;
  localparam int CTRL_PAR_B = 13;
  localparam int CTRL_OREG_A = 14;
  localparam int CTRL_OREG_B = 15;
  localparam int CTRL_PSEUDO = 16;
  localparam logic [16:0] CTRL_RST = 17'h0c000;
  localparam logic [11:0] SHIFT_RST = 12'h010;
  // Status register fields
  localparam int STAT_COLL_LSB = 0;
  localparam int STAT_CLASH_LSB = 8;
  localparam int STAT_OK_BIT = 16;
  // User port request
  typedef struct packed {
    logic en;
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] be;
    logic [DATA_W-1:0] din;
  } cfgbr_req_t;
  // Port shape
  typedef struct packed {
    logic [2:0] wc;
    logic par;
  } cfgbr_shape_t;
  // Address map result
  typedef struct packed {
    logic [8:0] base;
    logic [2:0] lanes;
    logic [2:0] off;
  } cfgbr_map_t;
  // One byte-lane write
  typedef struct packed {
    logic en;
    logic [8:0] idx;
    logic [8:0] mask;
    logic [8:0] dat;
  } cfgbr_lane_t;
endpackage : cfgbr_pkg

// File: hdl/cfgbr_ram.sv
// Configurable dual-port block RAM with APB configuration registers
//
// Summary of operation
// - True dual-port: both ports read or write together
// - Simple dual-port: port A writes, B reads
// - Single-port shares port A; read+write in one request is performed and counted as a clash
// - Two single-port RAMs in separate halves
// - Ports may use different data widths
// - Inputs registered; internal one-cycle write strobe
// - Output register selectable per port
// - Pseudo-async read: negedge address, no output register
// - Contents preloaded from an initialization image
// - One extra stored bit per data byte
// - Byte enables mask written lanes
// - Shift: read old, write new, one cycle
// - Port shapes 4Kx1 up to 128x36
// - No 128-deep shape in true dual-port
// - Simple dual-port: parity widths pair among themselves
// - True dual-port: widths up to 16/18 only
// - Byte masking for 16/18/32/36 wide; others kept
// - Per-port enables and asynchronous clears
// - Write side and read side registers separate
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module cfgbr_ram #(
  parameter logic [cfgbr_pkg::MEM_BYTES*cfgbr_pkg::BYTE_W-1:0]
    INIT_IMAGE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clr_a,
  input wire logic clr_b,
  input wire cfgbr_pkg::cfgbr_req_t port_a_i,
  input wire cfgbr_pkg::cfgbr_req_t port_b_i,
  output logic [cfgbr_pkg::DATA_W-1:0] dout_a,
  output logic [cfgbr_pkg::DATA_W-1:0] dout_b
);

  // Sub-word mask for narrow widths
  function automatic logic [7:0] nmask(input logic [2:0] wc);
    case (wc)
      cfgbr_pkg::WC_1: nmask = 8'h01;
      cfgbr_pkg::WC_2: nmask = 8'h03;
      cfgbr_pkg::WC_4: nmask = 8'h0f;
      default: nmask = 8'hff;
    endcase
  endfunction : nmask

  // Word address to byte index, lane count and bit offset
  function automatic cfgbr_pkg::cfgbr_map_t map_addr(
    input logic [2:0] wc, input logic [11:0] a, input logic half,
    input logic hi);
    cfgbr_pkg::cfgbr_map_t m;
    m = '0;
    m.lanes = 3'h1;
    case (wc) // LSB-first sub-word order
      cfgbr_pkg::WC_1:
      begin
        m.base = a[11:3];
        m.off = a[2:0];
      end
      cfgbr_pkg::WC_2:
      begin
        m.base = a[10:2];
        m.off = {a[1:0], 1'b0};
      end
      cfgbr_pkg::WC_4:
      begin
        m.base = a[9:1];
        m.off = {a[0], 2'b00};
      end
      cfgbr_pkg::WC_8: m.base = a[8:0];
      cfgbr_pkg::WC_16:
      begin
        m.base = {a[7:0], 1'b0};
        m.lanes = 3'h2;
      end
      default:
      begin
        m.base = {a[6:0], 2'b00};
        m.lanes = 3'h4;
      end
    endcase
    if (half)
    begin
      m.base[8] = hi; // Each single-port RAM owns one half
    end
    return m;
  endfunction : map_addr

  // Byte-lane write of one port
  function automatic cfgbr_pkg::cfgbr_lane_t lane_wr(
    input cfgbr_pkg::cfgbr_shape_t s, input cfgbr_pkg::cfgbr_map_t m,
    input cfgbr_pkg::cfgbr_req_t r, input logic ok, input int l);
    cfgbr_pkg::cfgbr_lane_t o;
    o = '0;
    o.idx = m.base + 9'(l);
    // Lanes of 16/18/32/36-wide shapes honour byte enables
    o.en = ok && (3'(l) < m.lanes) && (s.wc < cfgbr_pkg::WC_16 || r.be[l]);
    if (s.par)
    begin
      o.dat = r.din[9*l +: 9]; // Extra stored bit per byte
      o.mask = 9'h1ff;
    end
    else if (s.wc >= cfgbr_pkg::WC_8)
    begin
      o.dat = {1'b0, r.din[8*l +: 8]};
      o.mask = 9'h0ff;
    end
    else
    begin
      o.mask = {1'b0, nmask(s.wc) << m.off};
      o.dat = {1'b0, r.din[7:0] << m.off};
    end
    return o;
  endfunction : lane_wr

  // Assemble a read word from four stored bytes
  function automatic logic [35:0] rd_word(
    input cfgbr_pkg::cfgbr_shape_t s, input logic [2:0] off,
    input logic [35:0] rb);
    logic [35:0] w;
    w = '0;
    case (s.wc)
      cfgbr_pkg::WC_8: w[8:0] = s.par ? rb[8:0] : {1'b0, rb[7:0]};
      cfgbr_pkg::WC_16:
        w[17:0] = s.par ? rb[17:0] : {2'h0, rb[16:9], rb[7:0]};
      cfgbr_pkg::WC_32:
        w = s.par ? rb : {4'h0, rb[34:27], rb[25:18], rb[16:9], rb[7:0]};
      default: w[7:0] = (rb[7:0] >> off) & nmask(s.wc);
    endcase
    return w;
  endfunction : rd_word

  // Legal shape combinations per mode
  function automatic logic cfg_legal(input logic [2:0] mode,
    input cfgbr_pkg::cfgbr_shape_t sa, input cfgbr_pkg::cfgbr_shape_t sb);
    logic ok;
    // Only the listed shapes exist, parity only from 9 wide
    ok = sa.wc <= cfgbr_pkg::WC_32 && sb.wc <= cfgbr_pkg::WC_32 &&
      !(sa.par && sa.wc < cfgbr_pkg::WC_8) &&
      !(sb.par && sb.wc < cfgbr_pkg::WC_8);
    case (mode)
      // No 128-deep shape, parity widths pair alone
      cfgbr_pkg::MODE_TDP: ok = ok && sa.wc <= cfgbr_pkg::WC_16 &&
        sb.wc <= cfgbr_pkg::WC_16 && sa.par == sb.par;
      cfgbr_pkg::MODE_SDP: ok = ok && sa.par == sb.par;
      cfgbr_pkg::MODE_SP2: ok = ok && sa.wc <= cfgbr_pkg::WC_16 &&
        sb.wc <= cfgbr_pkg::WC_16;
      cfgbr_pkg::MODE_SP, cfgbr_pkg::MODE_ROM,
      cfgbr_pkg::MODE_SHIFT: ok = ok;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : cfg_legal

  logic [8:0] mem_reg [cfgbr_pkg::MEM_BYTES];
  logic [16:0] ctrl_reg, ctrl_next;
  logic [11:0] shift_len_reg, shift_len_next;
  logic [7:0] coll_reg, coll_next, clash_reg, clash_next;
  logic [31:0] prdata_reg, prdata_next;
  cfgbr_pkg::cfgbr_req_t req_a_reg, req_a_next, req_b_reg, req_b_next;
  logic [11:0] ptr_reg, ptr_next, neg_addr_b_reg;
  logic [35:0] dout_a_reg, dout_a_next, dout_b_reg, dout_b_next;
  cfgbr_pkg::cfgbr_shape_t sa, sb;
  cfgbr_pkg::cfgbr_map_t ma, mb;
  cfgbr_pkg::cfgbr_req_t eff_a;
  cfgbr_pkg::cfgbr_lane_t la [cfgbr_pkg::LANES];
  cfgbr_pkg::cfgbr_lane_t lb [cfgbr_pkg::LANES];
  logic [2:0] mode;
  logic cfg_ok, half, wr_a, wr_b, rd_a, rd_b, shifting, clash, coll;
  logic oreg_a, oreg_b, pseudo;
  logic [35:0] rb_a, rb_b, rdata_a, rdata_b;
  logic [11:0] raddr_b;

  // Configuration decode and per-port permissions
  always_comb
  begin
    mode = ctrl_reg[cfgbr_pkg::CTRL_MODE_LSB +: 3];
    sa = {ctrl_reg[cfgbr_pkg::CTRL_WA_LSB +: 3],
      ctrl_reg[cfgbr_pkg::CTRL_PAR_A]};
    sb = {ctrl_reg[cfgbr_pkg::CTRL_WB_LSB +: 3],
      ctrl_reg[cfgbr_pkg::CTRL_PAR_B]};
    cfg_ok = cfg_legal(mode, sa, sb);
    half = mode == cfgbr_pkg::MODE_SP2;
    shifting = mode == cfgbr_pkg::MODE_SHIFT;
    // Pseudo-async read only in simple dual-port
    pseudo = ctrl_reg[cfgbr_pkg::CTRL_PSEUDO] && mode == cfgbr_pkg::MODE_SDP;
    oreg_a = ctrl_reg[cfgbr_pkg::CTRL_OREG_A];
    oreg_b = ctrl_reg[cfgbr_pkg::CTRL_OREG_B] && !pseudo;
    eff_a = req_a_reg;
    if (shifting)
    begin
      eff_a.addr = ptr_reg; // Shift walks a circular window
      eff_a.we = 1'b1;
      eff_a.re = 1'b1;
    end
    // Port roles per mode
    wr_a = cfg_ok && eff_a.en && eff_a.we && mode != cfgbr_pkg::MODE_ROM;
    wr_b = cfg_ok && req_b_reg.en && req_b_reg.we &&
      (mode == cfgbr_pkg::MODE_TDP || half);
    rd_a = cfg_ok && eff_a.en && eff_a.re && mode != cfgbr_pkg::MODE_SDP;
    rd_b = cfg_ok && (pseudo || (req_b_reg.en && req_b_reg.re)) &&
      mode != cfgbr_pkg::MODE_SP && !shifting;
    clash = mode == cfgbr_pkg::MODE_SP && req_a_reg.en && req_a_reg.we &&
      req_a_reg.re;
    raddr_b = pseudo ? neg_addr_b_reg : req_b_reg.addr;
    ma = map_addr(sa.wc, eff_a.addr, half, 1'b0);
    mb = map_addr(sb.wc, wr_b ? req_b_reg.addr : raddr_b, half, 1'b1);
  end

  // Lane writes of both ports
  genvar gl;
  generate
    for (gl = 0; gl < cfgbr_pkg::LANES; gl++)
    begin : g_lane
      assign la[gl] = lane_wr(sa, ma, eff_a, wr_a, gl);
      assign lb[gl] = lane_wr(sb, mb, req_b_reg, wr_b, gl);
      assign rb_a[9*gl +: 9] = mem_reg[ma.base + 9'(gl)];
      assign rb_b[9*gl +: 9] = mem_reg[mb.base + 9'(gl)];
    end
  endgenerate

  // Same-byte collision between ports
  always_comb
  begin
    coll = 1'b0;
    for (int i = 0; i < cfgbr_pkg::LANES; i++)
    begin
      for (int j = 0; j < cfgbr_pkg::LANES; j++)
      begin
        if (la[i].en && lb[j].en && la[i].idx == lb[j].idx)
        begin
          coll = 1'b1;
        end
      end
    end
  end

  // Array: preload, then masked writes, port A last so it wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < cfgbr_pkg::MEM_BYTES; i++)
      begin
        mem_reg[i] <= INIT_IMAGE[9*i +: 9];
      end
    end
    else
    begin
      for (int l = 0; l < cfgbr_pkg::LANES; l++)
      begin
        if (lb[l].en)
        begin
          mem_reg[lb[l].idx] <= (mem_reg[lb[l].idx] & ~lb[l].mask) |
            (lb[l].dat & lb[l].mask);
        end
      end
      for (int l = 0; l < cfgbr_pkg::LANES; l++)
      begin
        if (la[l].en)
        begin
          mem_reg[la[l].idx] <= (mem_reg[la[l].idx] & ~la[l].mask) |
            (la[l].dat & la[l].mask);
        end
      end
    end
  end

  // Read data, output registers and shift pointer next values
  always_comb
  begin
    rdata_a = rd_word(sa, ma.off, rb_a);
    rdata_b = rd_word(sb, mb.off, rb_b);
    // Captured before the write lands: one-cycle shift
    dout_a_next = rd_a ? rdata_a : dout_a_reg;
    dout_b_next = rd_b ? rdata_b : dout_b_reg;
    req_a_next = port_a_i; // All inputs registered
    req_b_next = port_b_i;
    ptr_next = ptr_reg;
    if (shifting && wr_a)
    begin
      ptr_next = (ptr_reg + 12'h001 >= shift_len_reg) ? 12'h000 :
        ptr_reg + 12'h001;
    end
  end

  // Port A registers, own asynchronous clear
  always_ff @(posedge pclk or negedge presetn or posedge clr_a)
  begin
    if (!presetn || clr_a)
    begin
      req_a_reg <= '0;
      dout_a_reg <= '0;
      ptr_reg <= '0;
    end
    else
    begin
      req_a_reg <= req_a_next;
      dout_a_reg <= dout_a_next;
      ptr_reg <= ptr_next;
    end
  end

  // Port B registers, own asynchronous clear
  always_ff @(posedge pclk or negedge presetn or posedge clr_b)
  begin
    if (!presetn || clr_b)
    begin
      req_b_reg <= '0;
      dout_b_reg <= '0;
    end
    else
    begin
      req_b_reg <= req_b_next;
      dout_b_reg <= dout_b_next;
    end
  end

  // Falling-edge read address for pseudo-async read
  always_ff @(negedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      neg_addr_b_reg <= '0;
    end
    else
    begin
      neg_addr_b_reg <= port_b_i.addr;
    end
  end

  // Registered or bypassed read data
  assign dout_a = oreg_a ? dout_a_reg : (rd_a ? rdata_a : '0);
  assign dout_b = oreg_b ? dout_b_reg : (rd_b ? rdata_b : '0);

  // APB register file next values
  always_comb
  begin
    ctrl_next = ctrl_reg;
    shift_len_next = shift_len_reg;
    coll_next = coll_reg;
    clash_next = clash_reg;
    prdata_next = prdata_reg;
    if (psel && penable && pwrite)
    begin
      case (paddr)
        cfgbr_pkg::CTRL_OFF: ctrl_next = pwdata[16:0];
        cfgbr_pkg::SHIFT_OFF: shift_len_next = pwdata[11:0];
        cfgbr_pkg::STAT_OFF:
        begin
          coll_next = '0;
          clash_next = '0;
        end
        default: ;
      endcase
    end
    // Events win over a clear in the same cycle unless the count stands at ff
    if (coll && coll_reg != 8'hff)
    begin
      coll_next = (coll_next == coll_reg) ? coll_reg + 8'h01 : 8'h01;
    end
    if (clash && clash_reg != 8'hff)
    begin
      clash_next = (clash_next == clash_reg) ? clash_reg + 8'h01 : 8'h01;
    end
    if (psel && !penable)
    begin
      case (paddr)
        cfgbr_pkg::CTRL_OFF: prdata_next = {15'h0, ctrl_reg};
        cfgbr_pkg::SHIFT_OFF: prdata_next = {20'h0, shift_len_reg};
        cfgbr_pkg::STAT_OFF:
          prdata_next = {15'h0, cfg_ok, clash_reg, coll_reg};
        default: prdata_next = '0;
      endcase
    end
  end

  // APB registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= cfgbr_pkg::CTRL_RST;
      shift_len_reg <= cfgbr_pkg::SHIFT_RST;
      coll_reg <= '0;
      clash_reg <= '0;
      prdata_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      shift_len_reg <= shift_len_next;
      coll_reg <= coll_next;
      clash_reg <= clash_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != cfgbr_pkg::CTRL_OFF &&
    paddr != cfgbr_pkg::SHIFT_OFF && paddr != cfgbr_pkg::STAT_OFF;

  // Checks on the array ports
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || clr_a || clr_b);

  AST_STROBE_FROM_INPUT: assert property (
    wr_a && !shifting |-> $past(port_a_i.en && port_a_i.we))
    else $error("write strobe without registered request");
  AST_ROM_NO_WRITE: assert property (
    mode == cfgbr_pkg::MODE_ROM |-> !la[0].en && !lb[0].en)
    else $error("write in rom mode");
  AST_SDP_B_READS: assert property (
    mode == cfgbr_pkg::MODE_SDP |-> !wr_b)
    else $error("read port wrote in simple dual-port");
  AST_SP_B_IDLE: assert property (
    mode == cfgbr_pkg::MODE_SP |-> !wr_b && !rd_b)
    else $error("port b active in single-port");
  AST_SP2_HALVES: assert property (
    half && la[0].en && lb[0].en |-> !la[0].idx[8] && lb[0].idx[8])
    else $error("single-port halves overlap");
  AST_OREG_LATENCY: assert property (
    oreg_a && rd_a && $stable(ctrl_reg) |=> dout_a == $past(rdata_a))
    else $error("output register latency wrong");
  AST_BE_MASK: assert property (
    sa.wc >= cfgbr_pkg::WC_16 && la[1].en |-> req_a_reg.be[1])
    else $error("masked lane written");
  AST_TDP_NO_WIDE: assert property (
    mode == cfgbr_pkg::MODE_TDP && sa.wc == cfgbr_pkg::WC_32 |-> !cfg_ok)
    else $error("wide shape accepted in true dual-port");
  AST_NARROW_LSB: assert property (
    sa.wc == cfgbr_pkg::WC_1 && la[0].en |->
      la[0].mask == (9'h001 << eff_a.addr[2:0]))
    else $error("narrow bit position wrong");
  AST_SHIFT_WRAP: assert property (
    shifting && wr_a && ptr_reg + 12'h001 >= shift_len_reg && $stable(ctrl_reg)
      |=> ptr_reg == 12'h000)
    else $error("shift pointer did not wrap");

  COV_TDP_BOTH_WRITE: cover property (
    mode == cfgbr_pkg::MODE_TDP && wr_a && wr_b);
  COV_COLLISION: cover property (coll);
  COV_PSEUDO_READ: cover property (pseudo && rd_b);
  COV_SHIFT_WRAP: cover property (shifting && wr_a && ptr_reg == 12'h000);

endmodule : cfgbr_ram

// File: testbench/cfgbr_user_model.sv
// User-logic model that drives one request port of the block RAM
`timescale 1ns/100ps
module cfgbr_user_model (
  input wire logic pclk,
  output cfgbr_pkg::cfgbr_req_t req
);
  // Port idles with every strobe low
  initial req = '0;

  // One request held for exactly one sampling edge, then released
  // Both strobes together only when a test asks for it
  // Tests never write one location from both ports at once
  task automatic op(input logic we, input logic re, input logic [11:0] a,
                    input logic [3:0] be, input logic [35:0] d);
    @(posedge pclk);
    req <= '{en: 1'b1, we: we, re: re, addr: a, be: be, din: d};
    @(posedge pclk);
    req <= '0;
  endtask : op
endmodule : cfgbr_user_model

// File: testbench/tb_top.sv
// Self-checking bench for the configurable block RAM
`timescale 1ns/100ps
module tb_top;
  localparam logic [4607:0] IMG = 4608'h0a5 << 45;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clr_a = 1'b0;
  logic clr_b = 1'b0;
  cfgbr_pkg::cfgbr_req_t req_a;
  cfgbr_pkg::cfgbr_req_t req_b;
  logic [35:0] dout_a;
  logic [35:0] dout_b;
  logic [31:0] rd;
  logic se;
  int err_total = 0;
  int checks_done = 0;

  // Bus clock, 40 ns period
  always #20 pclk = ~pclk;

  cfgbr_ram #(.INIT_IMAGE(IMG)) cfgbr_ram_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .clr_a(clr_a),
    .clr_b(clr_b),
    .port_a_i(req_a),
    .port_b_i(req_b),
    .dout_a(dout_a),
    .dout_b(dout_b)
  );
  cfgbr_user_model ua (.pclk(pclk), .req(req_a));
  cfgbr_user_model ub (.pclk(pclk), .req(req_b));

  // Compare and count
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Print counts and verdict, then stop
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // One APB transfer; response taken at the completing edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      err_total++;
      report_and_stop();
    end
  endtask : apb

  // Load the control register
  task automatic setc(input logic [16:0] v);
    apb(1'b1, cfgbr_pkg::CTRL_OFF, {15'h0, v});
  endtask : setc

  // Write one word through port A or B
  task automatic wrw(input bit b, input logic [11:0] a, input logic [3:0] be,
                     input logic [35:0] d);
    if (b)
      ub.op(1'b1, 1'b0, a, be, d);
    else
      ua.op(1'b1, 1'b0, a, be, d);
  endtask : wrw

  // Read one word through port A or B, registered or bypassed
  task automatic rdw(input bit b, input logic [11:0] a, input bit oreg,
                     output logic [35:0] q);
    if (b)
      ub.op(1'b0, 1'b1, a, 4'h0, 36'h0);
    else
      ua.op(1'b0, 1'b1, a, 4'h0, 36'h0);
    if (oreg)
      @(posedge pclk);
    #1;
    q = b ? dout_b : dout_a;
  endtask : rdw

  // Reset values of registers and an unmapped offset
  task automatic t_regs;
    apb(1'b0, cfgbr_pkg::CTRL_OFF, 32'h0);
    chk({4'h0, rd}, 36'h00000c000);
    apb(1'b0, cfgbr_pkg::SHIFT_OFF, 32'h0);
    chk({4'h0, rd}, 36'h000000010);
    apb(1'b0, cfgbr_pkg::STAT_OFF, 32'h0);
    chk({4'h0, rd}, 36'h000010000);
    apb(1'b1, 12'h00c, 32'hffffffff);
    chk({35'h0, se}, 36'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk({3'h0, se, rd}, 36'h100000000);
    $display("test regs done");
  endtask : t_regs

  // Preload, parity bit and parallel traffic on both ports
  task automatic t_init;
    logic [35:0] qa;
    logic [35:0] qb;
    setc(17'h0f330);
    rdw(1'b0, 12'h005, 1'b1, qa);
    chk(qa, 36'h0a5);
    fork
      wrw(1'b0, 12'h007, 4'h1, 36'h1c3);
      wrw(1'b1, 12'h009, 4'h1, 36'h05a);
    join
    fork
      rdw(1'b0, 12'h009, 1'b1, qa);
      rdw(1'b1, 12'h007, 1'b1, qb);
    join
    chk(qa, 36'h05a);
    chk(qb, 36'h1c3);
    $display("test init done");
  endtask : t_init

  // Bytes written narrow on A, word read wide on B
  task automatic t_mixed;
    logic [35:0] q;
    setc(17'h0c430);
    wrw(1'b0, 12'h002, 4'h1, 36'h34);
    wrw(1'b0, 12'h003, 4'h1, 36'h12);
    rdw(1'b1, 12'h001, 1'b1, q);
    chk(q & 36'hffff, 36'h1234);
    $display("test mixed done");
  endtask : t_mixed

  // Byte lanes masked, bypassed read beside a write
  task automatic t_bytes;
    logic [35:0] q;
    setc(17'h04551);
    wrw(1'b0, 12'h004, 4'hf, 36'h11223344);
    wrw(1'b0, 12'h004, 4'h5, 36'haabbccdd);
    fork
      wrw(1'b0, 12'h005, 4'hf, 36'h55667788);
      rdw(1'b1, 12'h004, 1'b0, q);
    join
    chk(q & 36'hffffffff, 36'h11bb33dd);
    rdw(1'b1, 12'h005, 1'b0, q);
    chk(q & 36'hffffffff, 36'h55667788);
    $display("test bytes done");
  endtask : t_bytes

  // Legal and illegal shapes seen in the ok status bit
  task automatic t_cfg;
    logic [16:0] cv [6];
    logic ok [6];
    cv = '{17'h0c050, 17'h0e340, 17'h0f340, 17'h0e551, 17'h0c501, 17'h0c006};
    ok = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++)
    begin
      setc(cv[i]);
      apb(1'b0, cfgbr_pkg::STAT_OFF, 32'h0);
      chk({35'h0, rd[16]}, {35'h0, ok[i]});
    end
    $display("test cfg done");
  endtask : t_cfg

  // Single-port clash counted; read-only mode ignores writes
  task automatic t_sp;
    logic [35:0] q;
    setc(17'h0c032);
    apb(1'b1, cfgbr_pkg::STAT_OFF, 32'h0);
    ua.op(1'b1, 1'b1, 12'h000, 4'h1, 36'h0);
    apb(1'b0, cfgbr_pkg::STAT_OFF, 32'h0);
    chk({28'h0, rd[15:8]}, 36'h1);
    setc(17'h0d034);
    wrw(1'b0, 12'h005, 4'h1, 36'h000);
    rdw(1'b0, 12'h005, 1'b1, q);
    chk(q, 36'h0a5);
    $display("test sp done");
  endtask : t_sp

  // Two single-port memories, then an asynchronous clear
  task automatic t_dual;
    logic [35:0] q;
    setc(17'h0c333);
    // Both halves written in the same cycle
    fork
      wrw(1'b0, 12'h000, 4'h1, 36'h11);
      wrw(1'b1, 12'h000, 4'h1, 36'h22);
    join
    rdw(1'b0, 12'h000, 1'b1, q);
    chk(q & 36'hff, 36'h11);
    rdw(1'b1, 12'h000, 1'b1, q);
    chk(q & 36'hff, 36'h22);
    @(posedge pclk);
    clr_b <= 1'b1;
    @(posedge pclk);
    clr_b <= 1'b0;
    #1;
    chk(dout_b, 36'h0);
    chk(dout_a & 36'hff, 36'h11);
    $display("test dual done");
  endtask : t_dual

  // Byte-wide line of four taps: 8x4x1 bits, one tap output, 4 checks
  task automatic t_shift;
    apb(1'b1, cfgbr_pkg::SHIFT_OFF, 32'h4);
    setc(17'h04035);
    for (int i = 0; i < 8; i++)
    begin
      ua.op(1'b1, 1'b1, 12'h000, 4'h1, 36'h10 + 36'(i));
      @(posedge pclk);
      #1;
      if (i >= 4)
        chk(dout_a, 36'h10 + 36'(i - 4));
    end
    $display("test shift done");
  endtask : t_shift

  // Read address taken on the falling edge, data before the next rise
  task automatic t_pseudo;
    logic [35:0] q;
    setc(17'h1c331);
    wrw(1'b0, 12'h00a, 4'h1, 36'h05c);
    fork
      ub.op(1'b0, 1'b1, 12'h00a, 4'h0, 36'h0);
      begin
        @(posedge pclk);
        @(negedge pclk);
        #1;
        q = dout_b;
      end
    join
    chk(q, 36'h05c);
    $display("test pseudo done");
  endtask : t_pseudo

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_init();
    t_mixed();
    t_bytes();
    t_cfg();
    t_sp();
    t_dual();
    t_shift();
    t_pseudo();
    report_and_stop();
  end
endmodule : tb_top
